// file: sim/cgrb_bank_properties.sv
// Purpose: port-level checks of the trim and pin register bank
// Assumes: one clock domain; each register on its own aligned word
// Notes: shadows follow committed writes so outputs can be tied to their cause
`include "cgrb_map.vh"

module cgrb_bank_props #(
    parameter PIN_COUNT = 4,
    parameter SIX_INPUT = 0
) (
    input wire CLOCK,
    input wire RESET_N,
    input wire [7:0] AVS_ADDRESS,
    input wire AVS_READ,
    input wire AVS_WRITE,
    input wire [31:0] AVS_WRITEDATA,
    input wire [3:0] AVS_BYTEENABLE,
    input wire [31:0] AVS_READDATA,
    input wire AVS_WAITREQUEST,
    input wire [PIN_COUNT-1:0] PIN_IN,
    input wire [PIN_COUNT-1:0] PIN_OUT,
    input wire [PIN_COUNT-1:0] PIN_OE,
    input wire [PIN_COUNT-1:0] ANALOG_CONNECT,
    input wire [15:0] OFFSET_TRIM,
    input wire [15:0] FULL_SCALE_TRIM,
    input wire [2:0] EFFECTIVE_GAIN,
    input wire INPUT_SWITCHES_OPEN
);
    timeunit 1ns;
    timeprecision 100ps;
    logic [2:0] sel_q;
    logic [2:0] gain_q;
    logic [PIN_COUNT-1:0] role_q;
    logic [PIN_COUNT-1:0] dir_q;
    wire [5:0] idx = AVS_ADDRESS[7:2];
    wire req = AVS_READ | AVS_WRITE;
    wire wr_ok = AVS_WRITE & ~AVS_WAITREQUEST & AVS_BYTEENABLE[0];
    wire rd_ok = AVS_READ & ~AVS_WAITREQUEST;
    wire sup = (sel_q == `CGRB_MEAS_AVDD4) | (sel_q == `CGRB_MEAS_DVDD4);
    wire opn = (sel_q != `CGRB_MEAS_OFF) & (sel_q <= `CGRB_MEAS_DVDD4);

    // shadows move on the commit edge, the same edge as the bank itself
    always @(posedge CLOCK or negedge RESET_N) begin
        if (!RESET_N) begin
            sel_q <= 3'h0;
            gain_q <= 3'h0;
            role_q <= '0;
            dir_q <= '0;
        end else if (wr_ok && idx == `CGRB_IDX_MEAS_CTRL) begin
            sel_q <= AVS_WRITEDATA[2:0];
            gain_q <= AVS_WRITEDATA[6:4];
        end else if (wr_ok && idx == `CGRB_IDX_PIN_ROLE) begin
            role_q <= AVS_WRITEDATA[PIN_COUNT-1:0];
        end else if (wr_ok && idx == `CGRB_IDX_PIN_DL) begin
            dir_q <= AVS_WRITEDATA[4+PIN_COUNT-1:4];
        end
    end

    default clocking @(posedge CLOCK); endclocking
    default disable iff (!RESET_N);

    // a fresh request waits exactly one cycle
    wait_one_a: assert property (req && !$past(req) |-> AVS_WAITREQUEST ##1 (!AVS_WAITREQUEST || !req))
        else $error("bus answer not after one wait cycle");
    gain_force_a: assert property (EFFECTIVE_GAIN == ($past(sup) ? 3'h0 : $past(gain_q)))
        else $error("applied gain wrong for measure select");
    switch_open_a: assert property (INPUT_SWITCHES_OPEN == $past(opn))
        else $error("input switches wrong for measure select");
    role_sep_a: assert property (SIX_INPUT == 0 && !opn && !INPUT_SWITCHES_OPEN |->
        ANALOG_CONNECT == ~role_q) else $error("analog connect does not follow role bits");
    ofs_lo_a: assert property (wr_ok && idx == `CGRB_IDX_OFS_LO |=>
        OFFSET_TRIM == {$past(OFFSET_TRIM[15:8]), $past(AVS_WRITEDATA[7:0])})
        else $error("offset trim low byte not stored");
    fs_hi_a: assert property (wr_ok && idx == `CGRB_IDX_GAIN_HI |=>
        FULL_SCALE_TRIM == {$past(AVS_WRITEDATA[7:0]), $past(FULL_SCALE_TRIM[7:0])})
        else $error("gain trim high byte not stored");
    trim_hold_a: assert property (!(wr_ok && idx >= 6'h0b && idx <= 6'h0f && idx != 6'h0d) |=>
        $stable(OFFSET_TRIM) && $stable(FULL_SCALE_TRIM)) else $error("trim moved without a write");
    pin_oe_a: assert property (PIN_OE == (role_q & ~dir_q))
        else $error("pin drive enable wrong");
    pin_level_a: assert property (wr_ok && idx == `CGRB_IDX_PIN_DL |=>
        (PIN_OUT & PIN_OE) == ($past(AVS_WRITEDATA[PIN_COUNT-1:0]) & PIN_OE))
        else $error("driven pin level wrong");
    rd_zero_a: assert property (rd_ok |-> AVS_READDATA[31:8] == 24'h0 &&
        (idx != `CGRB_IDX_RSVD_A && idx != `CGRB_IDX_RSVD_D || AVS_READDATA[7:0] == 8'h0) &&
        (idx != `CGRB_IDX_PIN_ROLE || AVS_READDATA[7:4] == 4'h0)) else $error("read bits not zero");

    cover property (wr_ok && idx == `CGRB_IDX_MEAS_CTRL);
    cover property (INPUT_SWITCHES_OPEN && EFFECTIVE_GAIN == 3'h0);
    cover property (rd_ok && idx == `CGRB_IDX_PIN_DL && |dir_q);
endmodule

bind cgrb_register_bank cgrb_bank_props #(.PIN_COUNT(PIN_COUNT), .SIX_INPUT(SIX_INPUT)) props (
    .CLOCK(CLOCK), .RESET_N(RESET_N), .AVS_ADDRESS(AVS_ADDRESS), .AVS_READ(AVS_READ),
    .AVS_WRITE(AVS_WRITE), .AVS_WRITEDATA(AVS_WRITEDATA), .AVS_BYTEENABLE(AVS_BYTEENABLE),
    .AVS_READDATA(AVS_READDATA), .AVS_WAITREQUEST(AVS_WAITREQUEST), .PIN_IN(PIN_IN),
    .PIN_OUT(PIN_OUT), .PIN_OE(PIN_OE), .ANALOG_CONNECT(ANALOG_CONNECT),
    .OFFSET_TRIM(OFFSET_TRIM), .FULL_SCALE_TRIM(FULL_SCALE_TRIM),
    .EFFECTIVE_GAIN(EFFECTIVE_GAIN), .INPUT_SWITCHES_OPEN(INPUT_SWITCHES_OPEN));

// file: sim/cgrb_pin_partner.sv
// Purpose: outside logic on the four general-purpose pads
// Assumes: its levels change just after a rising edge
// Notes: a pad nobody drives toggles, so a stale level never passes for a good one
module cgrb_pin_partner (
    input wire logic clock,
    input wire logic [3:0] pin_out,
    input wire logic [3:0] pin_oe,
    input wire logic [3:0] ext_en,
    input wire logic [3:0] ext_val,
    output logic [3:0] pad
);
    timeunit 1ns;
    timeprecision 100ps;
    logic flip = 1'b0;

    // floating pad stand-in
    always @(posedge clock) begin
        flip <= ~flip;
    end

    // the device wins where it drives; the outside only where it does not
    assign pad = (pin_oe & pin_out) | (~pin_oe & ext_en & ext_val) | (~pin_oe & ~ext_en & {4{flip}});
endmodule

// file: sim/cgrb_register_bank_tb.sv
// Purpose: self-checking bench for the trim and pin register bank
// Assumes: one wait cycle per access; bench waits on waitrequest anyway
// Notes: second instance is the six-input variant sharing the bus
module cgrb_register_bank_tb;
    timeunit 1ns;
    timeprecision 100ps;
    logic CLOCK, AVS_WAITREQUEST, INPUT_SWITCHES_OPEN;
    logic RESET_N = 1'b0;
    logic AVS_READ = 1'b0;
    logic AVS_WRITE = 1'b0;
    logic [7:0] AVS_ADDRESS = 8'h00;
    logic [31:0] AVS_WRITEDATA = 32'h0;
    logic [3:0] AVS_BYTEENABLE = 4'h0;
    logic [3:0] ext_en = 4'h0;
    logic [3:0] ext_val = 4'h0;
    logic [31:0] AVS_READDATA;
    logic [3:0] PIN_IN, PIN_OUT, PIN_OE, ANALOG_CONNECT, six_oe, six_ac;
    logic [15:0] OFFSET_TRIM, FULL_SCALE_TRIM;
    logic [2:0] EFFECTIVE_GAIN, g;
    logic [7:0] rd;
    int bad_count = 0;
    int cmp_count = 0;
    // rows: register index, write value, expected readback
    logic [21:0] rows [0:7] = '{{6'h0b, 8'ha5, 8'ha5}, {6'h0c, 8'h5a, 8'h5a}, {6'h0e, 8'h3c, 8'h3c},
        {6'h0f, 8'hc3, 8'hc3}, {6'h0a, 8'h00, 8'h00}, {6'h0d, 8'h00, 8'h00},
        {6'h11, 8'hff, 8'h0f}, {6'h3f, 8'hff, 8'h00}};

    cgrb_register_bank DUT (.CLOCK(CLOCK), .RESET_N(RESET_N), .AVS_ADDRESS(AVS_ADDRESS),
        .AVS_READ(AVS_READ), .AVS_WRITE(AVS_WRITE), .AVS_WRITEDATA(AVS_WRITEDATA),
        .AVS_BYTEENABLE(AVS_BYTEENABLE), .AVS_READDATA(AVS_READDATA),
        .AVS_WAITREQUEST(AVS_WAITREQUEST), .PIN_IN(PIN_IN), .PIN_OUT(PIN_OUT), .PIN_OE(PIN_OE),
        .ANALOG_CONNECT(ANALOG_CONNECT), .OFFSET_TRIM(OFFSET_TRIM),
        .FULL_SCALE_TRIM(FULL_SCALE_TRIM), .EFFECTIVE_GAIN(EFFECTIVE_GAIN),
        .INPUT_SWITCHES_OPEN(INPUT_SWITCHES_OPEN));
    cgrb_register_bank #(.SIX_INPUT(1)) DUT_SIX (.CLOCK(CLOCK), .RESET_N(RESET_N),
        .AVS_ADDRESS(AVS_ADDRESS), .AVS_READ(AVS_READ), .AVS_WRITE(AVS_WRITE),
        .AVS_WRITEDATA(AVS_WRITEDATA), .AVS_BYTEENABLE(AVS_BYTEENABLE), .AVS_READDATA(),
        .AVS_WAITREQUEST(), .PIN_IN(PIN_IN), .PIN_OUT(), .PIN_OE(six_oe), .ANALOG_CONNECT(six_ac),
        .OFFSET_TRIM(), .FULL_SCALE_TRIM(), .EFFECTIVE_GAIN(), .INPUT_SWITCHES_OPEN());
    cgrb_pin_partner PADS (.clock(CLOCK), .pin_out(PIN_OUT), .pin_oe(PIN_OE), .ext_en(ext_en),
        .ext_val(ext_val), .pad(PIN_IN));

    initial begin
        CLOCK = 1'b0;
        forever #5 CLOCK = ~CLOCK;
    end

    task print_verdict;
        $display("comparisons %0d mismatches %0d", cmp_count, bad_count);
        if (bad_count == 0 && cmp_count > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    task automatic chk(input logic [23:0] got, input logic [23:0] exp, input string what);
        cmp_count++;
        if (got !== exp) begin
            bad_count++;
            $display("[ERR] %0t %s: got %h expected %h", $time, what, got, exp);
        end
    endtask

    task automatic settle(input int k);
        repeat (k) @(posedge CLOCK);
        #1;
    endtask

    // one access; request held until waitrequest is seen low at an edge
    task automatic bus(input logic wr, input logic [5:0] idx, input logic [7:0] wd,
        input logic [3:0] be);
        int n = 0;
        @(posedge CLOCK);
        AVS_ADDRESS <= {idx, 2'b00};
        AVS_WRITE <= wr;
        AVS_READ <= ~wr;
        AVS_WRITEDATA <= {24'h0, wd};
        AVS_BYTEENABLE <= be;
        do begin
            @(posedge CLOCK);
            n++;
        end while (AVS_WAITREQUEST !== 1'b0 && n < 16);
        if (n >= 16) begin
            bad_count++;
            $display("[ERR] %0t bus access never answered", $time);
            print_verdict();
        end else begin
            rd = AVS_READDATA[7:0];
            AVS_READ <= 1'b0;
            AVS_WRITE <= 1'b0;
        end
    endtask

    initial begin
        repeat (8) @(posedge CLOCK);
        RESET_N <= 1'b1;
        settle(1);
        chk(FULL_SCALE_TRIM, 16'h4000, "gain trim reset");
        chk({PIN_OE, ANALOG_CONNECT}, 8'h0f, "pin reset");
        chk({six_oe, six_ac}, 8'h00, "six-input pins");
        for (int i = 10; i < 18; i++) begin
            bus(1'b0, i[5:0], 8'h00, 4'h1);
            chk(rd, (i == 15) ? 8'h40 : 8'h00, "reset readback");
        end
        $display("test reset values done");
        foreach (rows[i]) begin
            bus(1'b1, rows[i][21:16], rows[i][15:8], 4'h1);
            bus(1'b0, rows[i][21:16], 8'h00, 4'h1);
            chk(rd, rows[i][7:0], "readback");
        end
        bus(1'b1, 6'h0b, 8'h11, 4'h0);
        settle(1);
        chk(OFFSET_TRIM, 16'h5aa5, "offset trim");
        chk(FULL_SCALE_TRIM, 16'hc33c, "gain trim");
        $display("test register table done");
        bus(1'b1, 6'h11, 8'h00, 4'h1);
        for (int c = 0; c < 5; c++) begin
            g = (c == 2) ? 3'h2 : 3'h5; // gain kept at four for the sensor
            bus(1'b1, 6'h12, {1'b0, g, 1'b0, c[2:0]}, 4'h1);
            settle(1);
            chk(EFFECTIVE_GAIN, (c == 3 || c == 4) ? 3'h0 : g, "gain");
            chk({INPUT_SWITCHES_OPEN, ANALOG_CONNECT}, (c != 0) ? 5'h10 : 5'h0f, "switch");
            bus(1'b0, 6'h13, 8'h00, 4'h1);
            chk(rd, {4'h0, c != 0, (c == 3 || c == 4) ? 3'h0 : g}, "status");
        end
        bus(1'b1, 6'h12, 8'h00, 4'h1);
        $display("test measure select done");
        bus(1'b1, 6'h11, 8'h05, 4'h1);
        bus(1'b1, 6'h10, 8'h4f, 4'h1);
        ext_en <= 4'h4;
        ext_val <= 4'h4;
        settle(2);
        chk({PIN_OE, PIN_OUT[0], ANALOG_CONNECT}, 9'h03a, "pin drive");
        bus(1'b0, 6'h10, 8'h00, 4'h1);
        chk(rd, 8'h4f, "pad high");
        ext_val <= 4'h0;
        bus(1'b1, 6'h10, 8'h4f, 4'h1);
        bus(1'b0, 6'h10, 8'h00, 4'h1);
        chk(rd, 8'h4b, "pad low");
        bus(1'b1, 6'h10, 8'h0e, 4'h1);
        settle(1);
        chk({PIN_OE, PIN_OUT & PIN_OE}, 8'h54, "pin turned output");
        $display("test pins done");
        RESET_N <= 1'b0;
        settle(2);
        RESET_N <= 1'b1;
        settle(1);
        chk({FULL_SCALE_TRIM, OFFSET_TRIM[3:0], PIN_OE}, 24'h400000, "second reset");
        $display("test second reset done");
        print_verdict();
    end
endmodule

// file: verilog/cgrb_map.vh
// Purpose: offsets, field positions, reset values and codes of the trim and pin register bank
// Assumes: 8-bit registers, each on one aligned 32-bit Avalon word (byte address = 4 * index)
// Notes: indices are register numbers; the bus decodes address[7:2]
`ifndef CGRB_MAP_VH
`define CGRB_MAP_VH

// register indices
`define CGRB_IDX_RSVD_A 6'h0a
`define CGRB_IDX_OFS_LO 6'h0b
`define CGRB_IDX_OFS_HI 6'h0c
`define CGRB_IDX_RSVD_D 6'h0d
`define CGRB_IDX_GAIN_LO 6'h0e
`define CGRB_IDX_GAIN_HI 6'h0f
`define CGRB_IDX_PIN_DL 6'h10
`define CGRB_IDX_PIN_ROLE 6'h11
`define CGRB_IDX_MEAS_CTRL 6'h12
`define CGRB_IDX_MEAS_STAT 6'h13

// reset values
`define CGRB_RST_ZERO 8'h00
`define CGRB_RST_GAIN_HI 8'h40
`define CGRB_RST_NIB 4'h0
`define CGRB_RST_SEL 3'h0

// field positions
`define CGRB_DIR_MSB 7
`define CGRB_DIR_LSB 4
`define CGRB_LVL_MSB 3
`define CGRB_LVL_LSB 0
`define CGRB_ROLE_MSB 3
`define CGRB_ROLE_LSB 0
`define CGRB_SEL_MSB 2
`define CGRB_SEL_LSB 0
`define CGRB_GAIN_MSB 6
`define CGRB_GAIN_LSB 4

// supervisory measure codes
`define CGRB_MEAS_OFF 3'h0
`define CGRB_MEAS_MID 3'h1
`define CGRB_MEAS_TEMP 3'h2
`define CGRB_MEAS_AVDD4 3'h3
`define CGRB_MEAS_DVDD4 3'h4

// gain codes: 0 is unity, 2 is gain of four
`define CGRB_GAIN_UNITY 3'h0
`define CGRB_GAIN_TEMP_MAX 3'h2

`endif

// file: verilog/cgrb_measure_ctrl.v
// Purpose: gain forcing and input switch control from the supervisory measure select
// Assumes: purely combinational; the caller registers the results
// Notes: temp_gain_fault only reports software misuse, it changes nothing
`include "cgrb_map.vh"

module cgrb_measure_ctrl (
    input wire [2:0] measure_sel,
    input wire [2:0] gain_req,
    output reg [2:0] gain_eff,
    output reg switches_open,
    output reg temp_gain_fault
);

    // decode the measure code into gain and switch effects
    always @* begin
        gain_eff = gain_req;
        switches_open = 1'b0;
        temp_gain_fault = 1'b0;
        case (measure_sel)
            `CGRB_MEAS_MID: begin
                switches_open = 1'b1;
            end
            `CGRB_MEAS_TEMP: begin
                switches_open = 1'b1;
                // larger gains push the sensor out of the amplifier range
                temp_gain_fault = (gain_req > `CGRB_GAIN_TEMP_MAX);
            end
            `CGRB_MEAS_AVDD4, `CGRB_MEAS_DVDD4: begin
                switches_open = 1'b1;
                gain_eff = `CGRB_GAIN_UNITY;
            end
            default: begin
                gain_eff = gain_req;
            end
        endcase
    end

endmodule

// file: verilog/cgrb_pin_cell.v
// Purpose: one general-purpose pin: direction bit, level bit and pad drive
// Assumes: pin_in is synchronous to clock
// Notes: the level bit follows the pad only while the pin is a digital input
`include "cgrb_map.vh"

module cgrb_pin_cell (
    input wire clock,
    input wire reset_n,
    input wire wr_en,
    input wire wr_dir,
    input wire wr_lvl,
    input wire role,
    input wire pin_in,
    output reg dir_reg,
    output reg lvl_reg,
    output wire pin_out,
    output wire pin_oe
);

    wire sample_pad;

    // an input pin reflects the pad, so software writes to its level are lost
    assign sample_pad = role & dir_reg;

    // direction and level storage
    always @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            dir_reg <= 1'b0;
            lvl_reg <= 1'b0;
        end else begin
            if (wr_en) begin
                dir_reg <= wr_dir;
            end
            // the written direction decides: a write that makes the pin an output sets its level
            if (wr_en & ~(role & wr_dir)) begin
                lvl_reg <= wr_lvl;
            end else if (sample_pad) begin
                lvl_reg <= pin_in;
            end
        end
    end

    // drive only when digital and output
    assign pin_out = lvl_reg;
    assign pin_oe = role & ~dir_reg;
endmodule

// file: verilog/cgrb_register_bank.v
// Purpose: trim and general-purpose pin register bank on an Avalon-MM slave
// Assumes: one clock, async active-low reset, pins synchronous to CLOCK
// Notes: 8-bit registers in the low byte of each word; upper bits read zero
//
// Operation
// - supply monitor selected forces amplifier gain to unity regardless of gain field.
// - mid-supply, temperature or supply monitor selected opens all external input switches.
// - reserved byte 0Ah resets and reads zero; software writes only zero.
// - reserved byte 0Dh resets and reads zero; software writes only zero.
// - register 0Bh holds offset trim low byte, read/write, reset zero.
// - register 0Ch holds offset trim high byte, read/write, reset zero.
// - register 0Eh holds gain trim low byte, read/write, reset zero.
// - register 0Fh holds gain trim high byte, read/write, reset 40h.
// - pin data bits 7:4 set direction; zero output (reset), one input.
// - pin data bits 3:0 carry pin levels, driven or sampled; reset zero.
// - role bits at 11h: zero analog input (reset), one digital pin.
// - role bit n controls general-purpose pin n only.
// - six-input variant pins start disabled until their role bits are set.
// - measure codes: 010 temperature, 011 analog supply/4, 100 digital supply/4.
//
// Added by the designer: the Avalon-MM interface to the registers.
`include "cgrb_map.vh"

module cgrb_register_bank #(
    parameter PIN_COUNT = 4,
    parameter SIX_INPUT = 0
) (
    input wire CLOCK,
    input wire RESET_N,
    input wire [7:0] AVS_ADDRESS,
    input wire AVS_READ,
    input wire AVS_WRITE,
    input wire [31:0] AVS_WRITEDATA,
    input wire [3:0] AVS_BYTEENABLE,
    output reg [31:0] AVS_READDATA,
    output wire AVS_WAITREQUEST,
    input wire [PIN_COUNT-1:0] PIN_IN,
    output wire [PIN_COUNT-1:0] PIN_OUT,
    output wire [PIN_COUNT-1:0] PIN_OE,
    output wire [PIN_COUNT-1:0] ANALOG_CONNECT,
    output wire [15:0] OFFSET_TRIM,
    output wire [15:0] FULL_SCALE_TRIM,
    output reg [2:0] EFFECTIVE_GAIN,
    output reg INPUT_SWITCHES_OPEN
);

    // bus handshake state
    reg ack_reg;
    wire request;
    wire commit;
    wire wr_commit;
    wire [5:0] word_index;
    wire [7:0] wbyte;

    // storage
    reg [7:0] offset_trim_low_reg;
    reg [7:0] offset_trim_high_reg;
    reg [7:0] gain_trim_low_reg;
    reg [7:0] gain_trim_high_reg;
    reg [3:0] pin_function_reg;
    reg [2:0] measure_sel_reg;
    reg [2:0] gain_req_reg;
    reg temp_gain_fault_reg;

    // read path
    reg [7:0] rd_byte;
    reg [31:0] readdata_next;

    // pin cell views
    wire [PIN_COUNT-1:0] dir_bits;
    wire [PIN_COUNT-1:0] lvl_bits;
    wire [PIN_COUNT-1:0] pin_role;
    wire wr_pin_dl;

    // measure decode results
    wire [2:0] gain_eff_next;
    wire switches_open_next;
    wire temp_gain_fault_next;

    // decode helpers
    wire hit_ofs_lo;
    wire hit_ofs_hi;
    wire hit_gain_lo;
    wire hit_gain_hi;
    wire hit_role;
    wire hit_meas;

    // a request is answered one cycle after it is first seen
    assign request = AVS_READ | AVS_WRITE;
    assign AVS_WAITREQUEST = request & ~ack_reg;
    assign commit = request & ack_reg;

    // only the low byte lane carries register data
    assign wr_commit = commit & AVS_WRITE & AVS_BYTEENABLE[0];
    assign word_index = AVS_ADDRESS[7:2];
    assign wbyte = AVS_WRITEDATA[7:0];

    // address decode
    assign hit_ofs_lo = (word_index == `CGRB_IDX_OFS_LO);
    assign hit_ofs_hi = (word_index == `CGRB_IDX_OFS_HI);
    assign hit_gain_lo = (word_index == `CGRB_IDX_GAIN_LO);
    assign hit_gain_hi = (word_index == `CGRB_IDX_GAIN_HI);
    assign hit_role = (word_index == `CGRB_IDX_PIN_ROLE);
    assign hit_meas = (word_index == `CGRB_IDX_MEAS_CTRL);
    assign wr_pin_dl = wr_commit & (word_index == `CGRB_IDX_PIN_DL);

    // acknowledge flop: high for exactly the answering cycle
    always @(posedge CLOCK or negedge RESET_N) begin
        if (!RESET_N) begin
            ack_reg <= 1'b0;
        end else begin
            ack_reg <= request & ~ack_reg;
        end
    end

    // offset trim low byte
    always @(posedge CLOCK or negedge RESET_N) begin
        if (!RESET_N) begin
            offset_trim_low_reg <= `CGRB_RST_ZERO;
        end else if (wr_commit & hit_ofs_lo) begin
            offset_trim_low_reg <= wbyte;
        end
    end

    // offset trim high byte
    always @(posedge CLOCK or negedge RESET_N) begin
        if (!RESET_N) begin
            offset_trim_high_reg <= `CGRB_RST_ZERO;
        end else if (wr_commit & hit_ofs_hi) begin
            offset_trim_high_reg <= wbyte;
        end
    end

    // gain trim low byte
    always @(posedge CLOCK or negedge RESET_N) begin
        if (!RESET_N) begin
            gain_trim_low_reg <= `CGRB_RST_ZERO;
        end else if (wr_commit & hit_gain_lo) begin
            gain_trim_low_reg <= wbyte;
        end
    end

    // gain trim high byte; 40h makes the combined trim unity
    always @(posedge CLOCK or negedge RESET_N) begin
        if (!RESET_N) begin
            gain_trim_high_reg <= `CGRB_RST_GAIN_HI;
        end else if (wr_commit & hit_gain_hi) begin
            gain_trim_high_reg <= wbyte;
        end
    end

    // pin role bits; the upper nibble is never stored
    always @(posedge CLOCK or negedge RESET_N) begin
        if (!RESET_N) begin
            pin_function_reg <= `CGRB_RST_NIB;
        end else if (wr_commit & hit_role) begin
            pin_function_reg <= wbyte[`CGRB_ROLE_MSB:`CGRB_ROLE_LSB];
        end
    end

    // measure select and requested gain
    always @(posedge CLOCK or negedge RESET_N) begin
        if (!RESET_N) begin
            measure_sel_reg <= `CGRB_RST_SEL;
            gain_req_reg <= `CGRB_GAIN_UNITY;
        end else if (wr_commit & hit_meas) begin
            measure_sel_reg <= wbyte[`CGRB_SEL_MSB:`CGRB_SEL_LSB];
            gain_req_reg <= wbyte[`CGRB_GAIN_MSB:`CGRB_GAIN_LSB];
        end
    end

    // trims leave the bank as single 16-bit words
    assign OFFSET_TRIM = {offset_trim_high_reg, offset_trim_low_reg};
    assign FULL_SCALE_TRIM = {gain_trim_high_reg, gain_trim_low_reg};

    // gain forcing and switch opening
    cgrb_measure_ctrl u_measure (
        .measure_sel(measure_sel_reg),
        .gain_req(gain_req_reg),
        .gain_eff(gain_eff_next),
        .switches_open(switches_open_next),
        .temp_gain_fault(temp_gain_fault_next)
    );

    // register the analog controls so they change cleanly once per write
    always @(posedge CLOCK or negedge RESET_N) begin
        if (!RESET_N) begin
            EFFECTIVE_GAIN <= `CGRB_GAIN_UNITY;
            INPUT_SWITCHES_OPEN <= 1'b0;
            temp_gain_fault_reg <= 1'b0;
        end else begin
            EFFECTIVE_GAIN <= gain_eff_next;
            INPUT_SWITCHES_OPEN <= switches_open_next;
            temp_gain_fault_reg <= temp_gain_fault_next;
        end
    end

    // one cell per pin; role bit n reaches only cell n
    genvar n;
    generate
        for (n = 0; n < PIN_COUNT; n = n + 1) begin : g_pin
            assign pin_role[n] = pin_function_reg[n];
            cgrb_pin_cell u_cell (
                .clock(CLOCK),
                .reset_n(RESET_N),
                .wr_en(wr_pin_dl),
                .wr_dir(wbyte[`CGRB_DIR_LSB + n]),
                .wr_lvl(wbyte[`CGRB_LVL_LSB + n]),
                .role(pin_role[n]),
                .pin_in(PIN_IN[n]),
                .dir_reg(dir_bits[n]),
                .lvl_reg(lvl_bits[n]),
                .pin_out(PIN_OUT[n]),
                .pin_oe(PIN_OE[n])
            );
            // the six-input variant has no analog path on these pins
            if (SIX_INPUT != 0) begin : g_six
                assign ANALOG_CONNECT[n] = 1'b0;
            end else begin : g_twelve
                assign ANALOG_CONNECT[n] = ~pin_role[n] & ~INPUT_SWITCHES_OPEN;
            end
        end
    endgenerate

    // read multiplexer; reserved and unmapped words read zero
    always @* begin
        rd_byte = `CGRB_RST_ZERO;
        case (word_index)
            `CGRB_IDX_RSVD_A: begin
                rd_byte = `CGRB_RST_ZERO;
            end
            `CGRB_IDX_OFS_LO: begin
                rd_byte = offset_trim_low_reg;
            end
            `CGRB_IDX_OFS_HI: begin
                rd_byte = offset_trim_high_reg;
            end
            `CGRB_IDX_RSVD_D: begin
                rd_byte = `CGRB_RST_ZERO;
            end
            `CGRB_IDX_GAIN_LO: begin
                rd_byte = gain_trim_low_reg;
            end
            `CGRB_IDX_GAIN_HI: begin
                rd_byte = gain_trim_high_reg;
            end
            `CGRB_IDX_PIN_DL: begin
                rd_byte = {dir_bits, lvl_bits};
            end
            `CGRB_IDX_PIN_ROLE: begin
                rd_byte = {4'h0, pin_function_reg};
            end
            `CGRB_IDX_MEAS_CTRL: begin
                rd_byte = {1'b0, gain_req_reg, 1'b0, measure_sel_reg};
            end
            `CGRB_IDX_MEAS_STAT: begin
                // live view of what the analog side really uses
                rd_byte = {3'h0, temp_gain_fault_reg, INPUT_SWITCHES_OPEN, EFFECTIVE_GAIN};
            end
            default: begin
                rd_byte = `CGRB_RST_ZERO;
            end
        endcase
        readdata_next = {24'h000000, rd_byte};
    end

    // read data is loaded in the cycle waitrequest drops and holds afterwards
    always @(posedge CLOCK or negedge RESET_N) begin
        if (!RESET_N) begin
            AVS_READDATA <= 32'h00000000;
        end else if (AVS_READ & ~ack_reg) begin
            AVS_READDATA <= readdata_next;
        end
    end

endmodule
